// >>> spz_pkg.sv
// Constants and types for the serial port block
package spz_pkg;
    localparam int          SPZ_AW          = 12;
    // Printed offsets are register indices; byte address is index*4
    localparam logic [7:0]  SPZ_IDX_CTRL_HI = 8'h00;
    localparam logic [7:0]  SPZ_IDX_CTRL_LO = 8'h01;
    localparam logic [7:0]  SPZ_IDX_BAUD    = 8'h03;
    localparam logic [7:0]  SPZ_IDX_DATA    = 8'hf0;
    localparam logic [7:0]  SPZ_CTRL_RST    = 8'h00;
    localparam logic [7:0]  SPZ_BAUD_RST    = 8'h00;
    localparam logic [7:0]  SPZ_DATA_RST    = 8'h00;
    localparam logic [3:0]  SPZ_OS_MID      = 4'h7;
    localparam logic [3:0]  SPZ_OS_LAST     = 4'hf;
    localparam logic [2:0]  SPZ_BIT_LAST    = 3'h7;

    typedef enum logic [1:0] {
        SPZ_M0 = 2'b00,
        SPZ_M1 = 2'b01,
        SPZ_M2 = 2'b10,
        SPZ_M3 = 2'b11
    } spz_mode_t;

    typedef enum logic [2:0] {
        SPZ_S_IDLE  = 3'b000,
        SPZ_S_START = 3'b001,
        SPZ_S_DATA  = 3'b010,
        SPZ_S_NINTH = 3'b011,
        SPZ_S_STOP  = 3'b100
    } spz_state_t;

    typedef struct packed {
        spz_mode_t mode;
        logic      mce;
        logic      rx_on;
        logic      tx_ninth_bit;
        logic      rx_ninth_bit;
        logic      rx_ie;
        logic      rx_pending_flag;
    } spz_ctrl_hi_t;

    typedef struct packed {
        logic       par_en;
        logic [2:0] spare;
        logic [1:0] clk_sel;
        logic       tx_ie;
        logic       tx_pending_flag;
    } spz_ctrl_lo_t;
endpackage

// >>> spz_serial_port.sv
// Serial port with synchronous shift mode and three asynchronous modes
module spz_serial_port
    import spz_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [SPZ_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              serial_in_i,
    output logic                   serial_in_o,
    output logic                   serial_in_oen,
    output logic                   serial_out_pin,
    output logic                   rx_irq,
    output logic                   tx_irq
);
    function automatic logic [SPZ_AW-1:0] reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic os_end(input logic tick, input logic [3:0] cnt);
        return tick && (cnt == SPZ_OS_LAST);
    endfunction

    // Software fields
    spz_mode_t    mode;
    logic         mce;
    logic         rx_on;
    logic         tx_ninth_bit;
    logic         rx_ie;
    logic         par_en;
    logic [2:0]   lo_spare;
    logic [1:0]   clk_sel;
    logic         tx_ie;
    logic [7:0]   baud_divisor;
    // Hardware status
    logic         rx_pending_flag;
    logic         tx_pending_flag;
    logic         rx_ninth_bit;
    logic [7:0]   rx_buf;
    logic [7:0]   tx_buf;
    logic         tx_req;
    spz_ctrl_hi_t hi_view;
    spz_ctrl_lo_t lo_view;

    // Bus decode
    logic setup;
    logic wr_en;
    logic wr_hi;
    logic wr_lo;
    logic wr_baud;
    logic wr_data;
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready && pwrite && pstrb[0];
    assign wr_hi   = wr_en && (paddr == reg_addr(SPZ_IDX_CTRL_HI));
    assign wr_lo   = wr_en && (paddr == reg_addr(SPZ_IDX_CTRL_LO));
    assign wr_baud = wr_en && (paddr == reg_addr(SPZ_IDX_BAUD));
    assign wr_data = wr_en && (paddr == reg_addr(SPZ_IDX_DATA));

    always_comb begin
        hi_view.mode            = mode;
        hi_view.mce             = mce;
        hi_view.rx_on           = rx_on;
        hi_view.tx_ninth_bit    = tx_ninth_bit;
        hi_view.rx_ninth_bit    = rx_ninth_bit;
        hi_view.rx_ie           = rx_ie;
        hi_view.rx_pending_flag = rx_pending_flag;
        lo_view.par_en          = par_en;
        lo_view.spare           = lo_spare;
        lo_view.clk_sel         = clk_sel;
        lo_view.tx_ie           = tx_ie;
        lo_view.tx_pending_flag = tx_pending_flag;
    end

    // Zero wait state slave: ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    reg_addr(SPZ_IDX_CTRL_HI): prdata[7:0] <= hi_view;
                    reg_addr(SPZ_IDX_CTRL_LO): prdata[7:0] <= lo_view;
                    reg_addr(SPZ_IDX_BAUD):    prdata[7:0] <= baud_divisor;
                    reg_addr(SPZ_IDX_DATA):    prdata[7:0] <= rx_buf;
                    default:                   pslverr     <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode         <= spz_mode_t'(SPZ_CTRL_RST[7:6]);
            mce          <= SPZ_CTRL_RST[5];
            rx_on        <= SPZ_CTRL_RST[4];
            tx_ninth_bit <= SPZ_CTRL_RST[3];
            rx_ie        <= SPZ_CTRL_RST[1];
            par_en       <= SPZ_CTRL_RST[7];
            lo_spare     <= SPZ_CTRL_RST[6:4];
            clk_sel      <= SPZ_CTRL_RST[3:2];
            tx_ie        <= SPZ_CTRL_RST[1];
            baud_divisor <= SPZ_BAUD_RST;
        end else begin
            if (wr_hi) begin
                mode         <= spz_mode_t'(pwdata[7:6]);
                mce          <= pwdata[5];
                rx_on        <= pwdata[4];
                tx_ninth_bit <= pwdata[3];
                rx_ie        <= pwdata[1];
            end
            if (wr_lo) begin
                par_en   <= pwdata[7];
                lo_spare <= pwdata[6:4];
                clk_sel  <= pwdata[3:2];
                tx_ie    <= pwdata[1];
            end
            if (wr_baud) begin
                baud_divisor <= pwdata[7:0];
            end
        end
    end

    // Input pin synchroniser
    logic pin_meta;
    logic pin_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b1;
            pin_s    <= 1'b1;
        end else begin
            pin_meta <= serial_in_i;
            pin_s    <= pin_meta;
        end
    end

    // Functional clock prescaler and oversample tick
    logic [2:0] pre_cnt;
    logic [2:0] pre_mask;
    logic       fu_tick;
    logic [7:0] baud_cnt;
    logic       os_tick;
    assign pre_mask = 3'((4'b0001 << clk_sel) - 4'b0001);
    assign fu_tick  = (pre_cnt & pre_mask) == pre_mask;
    // Mode 2 ignores divisor; others divide by divisor+1
    assign os_tick  = fu_tick && ((mode == SPZ_M2) || (baud_cnt == baud_divisor));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt  <= 3'h0;
            baud_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_cnt + 3'h1;
            if (os_tick || mode == SPZ_M2) begin
                baud_cnt <= 8'h00;
            end else if (fu_tick) begin
                baud_cnt <= baud_cnt + 8'h01;
            end
        end
    end

    // Transmit and mode 0 shift engine
    spz_state_t tx_state;
    logic [3:0] tx_os;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic       tx9;
    logic       tx_m0;
    logic       m0_rx;
    logic       tx_bit_end;
    logic       m0_end;
    logic       tx_to_stop;
    logic       m0_sample;

    function automatic logic tx9_mode();
        return (mode == SPZ_M2) || (mode == SPZ_M3);
    endfunction

    assign tx_bit_end = os_end(os_tick, tx_os);
    assign m0_end     = tx_m0 && tx_state == SPZ_S_DATA && tx_bit_end && tx_bit == SPZ_BIT_LAST;
    assign tx_to_stop = !tx_m0 && tx_bit_end
                        && ((tx_state == SPZ_S_NINTH)
                            || (tx_state == SPZ_S_DATA && tx_bit == SPZ_BIT_LAST && !tx9_mode()));
    // Mode 0 samples where the shift clock rises
    assign m0_sample  = tx_m0 && m0_rx && tx_state == SPZ_S_DATA && os_tick && tx_os == SPZ_OS_MID;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf <= SPZ_DATA_RST;
            tx_req <= 1'b0;
        end else if (wr_data) begin
            tx_buf <= pwdata[7:0];
            tx_req <= 1'b1;
        end else if (tx_state == SPZ_S_IDLE) begin
            tx_req <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= SPZ_S_IDLE;
            tx_os    <= 4'h0;
            tx_bit   <= 3'h0;
            tx_shift <= 8'h00;
            tx9      <= 1'b0;
            tx_m0    <= 1'b0;
            m0_rx    <= 1'b0;
        end else begin
            if (os_tick) begin
                tx_os <= tx_os + 4'h1;
            end
            case (tx_state)
                SPZ_S_IDLE: begin
                    tx_os  <= 4'h0;
                    tx_bit <= 3'h0;
                    tx_m0  <= (mode == SPZ_M0);
                    if (tx_req) begin
                        tx_shift <= tx_buf;
                        // Parity replaces the written ninth bit when enabled
                        tx9      <= par_en ? ^tx_buf : tx_ninth_bit;
                        m0_rx    <= 1'b0;
                        tx_state <= (mode == SPZ_M0) ? SPZ_S_DATA : SPZ_S_START;
                    end else if (mode == SPZ_M0 && rx_on && !rx_pending_flag) begin
                        m0_rx    <= 1'b1;
                        tx_state <= SPZ_S_DATA;
                    end
                end
                SPZ_S_START: begin
                    if (tx_bit_end) begin
                        tx_state <= SPZ_S_DATA;
                    end
                end
                SPZ_S_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit   <= tx_bit + 3'h1;
                        if (tx_bit == SPZ_BIT_LAST) begin
                            if (tx_m0) begin
                                tx_state <= SPZ_S_IDLE;
                            end else begin
                                tx_state <= tx9_mode() ? SPZ_S_NINTH : SPZ_S_STOP;
                            end
                        end
                    end
                end
                SPZ_S_NINTH: begin
                    if (tx_bit_end) begin
                        tx_state <= SPZ_S_STOP;
                    end
                end
                SPZ_S_STOP: begin
                    if (tx_bit_end) begin
                        tx_state <= SPZ_S_IDLE;
                    end
                end
                default: tx_state <= SPZ_S_IDLE;
            endcase
        end
    end

    // Pin drivers, registered
    logic line_val;
    always_comb begin
        line_val = 1'b1;
        if (tx_m0) begin
            // Shift clock low first half, high second half
            line_val = !(tx_state == SPZ_S_DATA) || tx_os[3];
        end else begin
            case (tx_state)
                SPZ_S_START: line_val = 1'b0;
                SPZ_S_DATA:  line_val = tx_shift[0];
                SPZ_S_NINTH: line_val = tx9;
                default:     line_val = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
            serial_in_o    <= 1'b1;
            serial_in_oen  <= 1'b1;
        end else begin
            serial_out_pin <= line_val;
            serial_in_o    <= tx_shift[0];
            serial_in_oen  <= !(tx_m0 && !m0_rx && tx_state == SPZ_S_DATA);
        end
    end

    // Asynchronous receive engine
    spz_state_t rx_state;
    logic [3:0] rx_os;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic       rx_mid;
    logic       rx_bit_end;
    logic       async_load;
    logic       rx_done;
    assign rx_mid     = os_tick && rx_os == SPZ_OS_MID;
    assign rx_bit_end = os_end(os_tick, rx_os);
    // Mode 1 with mce keeps frames with a bad stop bit out
    assign async_load = rx_mid && ((rx_state == SPZ_S_NINTH)
                        || (rx_state == SPZ_S_STOP && mode == SPZ_M1 && (pin_s || !mce)));
    assign rx_done    = async_load || (m0_end && m0_rx);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= SPZ_S_IDLE;
            rx_os    <= 4'h0;
            rx_bit   <= 3'h0;
            rx_shift <= 8'h00;
        end else begin
            if (os_tick) begin
                rx_os <= rx_os + 4'h1;
            end
            if (m0_sample) begin
                rx_shift <= {pin_s, rx_shift[7:1]};
            end
            case (rx_state)
                SPZ_S_IDLE: begin
                    rx_os  <= 4'h0;
                    rx_bit <= 3'h0;
                    if (mode != SPZ_M0 && rx_on && !pin_s) begin
                        rx_state <= SPZ_S_START;
                    end
                end
                SPZ_S_START: begin
                    // A glitch shorter than half a bit is dropped
                    if (rx_mid && pin_s) begin
                        rx_state <= SPZ_S_IDLE;
                    end else if (rx_bit_end) begin
                        rx_state <= SPZ_S_DATA;
                    end
                end
                SPZ_S_DATA: begin
                    if (rx_mid) begin
                        rx_shift <= {pin_s, rx_shift[7:1]};
                    end
                    if (rx_bit_end) begin
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == SPZ_BIT_LAST) begin
                            rx_state <= tx9_mode() ? SPZ_S_NINTH : SPZ_S_STOP;
                        end
                    end
                end
                SPZ_S_NINTH: begin
                    if (rx_bit_end) begin
                        rx_state <= SPZ_S_STOP;
                    end
                end
                SPZ_S_STOP: begin
                    // Stop level unchecked in 9-bit modes; leave at mid bit
                    if (rx_mid) begin
                        rx_state <= SPZ_S_IDLE;
                    end
                end
                default: rx_state <= SPZ_S_IDLE;
            endcase
        end
    end

    // Overrun overwrites the older byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf       <= SPZ_DATA_RST;
            rx_ninth_bit <= SPZ_CTRL_RST[2];
        end else begin
            if (m0_end && m0_rx) begin
                rx_buf <= rx_shift;
            end else if (async_load) begin
                rx_buf <= rx_shift;
            end
            if (rx_mid && rx_state == SPZ_S_NINTH) begin
                rx_ninth_bit <= pin_s;
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pending_flag <= SPZ_CTRL_RST[0];
        end else if (rx_done) begin
            rx_pending_flag <= 1'b1;
        end else if (wr_hi && !pwdata[0]) begin
            rx_pending_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pending_flag <= SPZ_CTRL_RST[0];
        end else if ((m0_end && !m0_rx) || tx_to_stop) begin
            tx_pending_flag <= 1'b1;
        end else if (wr_lo && !pwdata[0]) begin
            tx_pending_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            rx_irq <= rx_pending_flag && rx_ie;
            tx_irq <= tx_pending_flag && tx_ie;
        end
    end
endmodule // spz_serial_port

// >>> spz_serial_port_checker.sv
// Port-level assertions for the serial port block
module spz_serial_port_checker
    import spz_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [SPZ_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              serial_in_i,
    input wire logic              serial_in_o,
    input wire logic              serial_in_oen,
    input wire logic              serial_out_pin,
    input wire logic              rx_irq,
    input wire logic              tx_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [SPZ_AW-1:0] A_HI   = SPZ_AW'({SPZ_IDX_CTRL_HI, 2'b00});
    localparam logic [SPZ_AW-1:0] A_LO   = SPZ_AW'({SPZ_IDX_CTRL_LO, 2'b00});
    localparam logic [SPZ_AW-1:0] A_BAUD = SPZ_AW'({SPZ_IDX_BAUD, 2'b00});
    localparam logic [SPZ_AW-1:0] A_DATA = SPZ_AW'({SPZ_IDX_DATA, 2'b00});
    logic       wr_ok;
    logic       mapped;
    logic [7:0] hi_sh;
    logic [7:0] baud_sh;

    assign wr_ok  = psel && penable && pready && pwrite && pstrb[0];
    assign mapped = paddr inside {A_HI, A_LO, A_BAUD, A_DATA};

    // Mirrors of the last software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_sh   <= 8'h00;
            baud_sh <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == A_HI) begin
                hi_sh <= pwdata[7:0];
            end
            if (paddr == A_BAUD) begin
                baud_sh <= pwdata[7:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_setup; psel && !penable |=> pready; endproperty
    property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_err_map; pready |-> pslverr == !mapped; endproperty
    property p_baud_back; pready && !pwrite && paddr == A_BAUD |-> prdata[7:0] == baud_sh; endproperty
    property p_rx_irq_off;
        wr_ok && paddr == A_HI && !(pwdata[0] && pwdata[1]) |-> ##[1:2] !rx_irq;
    endproperty
    property p_tx_irq_off;
        wr_ok && paddr == A_LO && !(pwdata[0] && pwdata[1]) |-> ##[1:2] !tx_irq;
    endproperty
    property p_oen_m0; !serial_in_oen |-> hi_sh[7:6] == 2'b00; endproperty
    // Bits last 16 oversample ticks, so a low stretch is never short
    property p_async_start;
        $fell(serial_out_pin) && hi_sh[7:6] != 2'b00 |=> !serial_out_pin [*8];
    endproperty
    property p_m0_clock;
        $rose(serial_out_pin) && hi_sh[7:6] == 2'b00 |=> serial_out_pin [*7];
    endproperty

    a_ready_setup: assert property (p_ready_setup) else $error("ready missing");
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits");
    a_err_map: assert property (p_err_map) else $error("slave error wrong");
    a_baud_back: assert property (p_baud_back) else $error("divisor readback");
    a_rx_irq_off: assert property (p_rx_irq_off) else $error("rx irq stays");
    a_tx_irq_off: assert property (p_tx_irq_off) else $error("tx irq stays");
    a_oen_m0: assert property (p_oen_m0) else $error("pin driven off mode 0");
    a_async_start: assert property (p_async_start) else $error("short low bit");
    a_m0_clock: assert property (p_m0_clock) else $error("short shift clock");

    c_rx_irq: cover property ($rose(rx_irq));
    c_err: cover property (pready && pslverr);
    c_m0_drive: cover property ($fell(serial_in_oen));
endmodule // spz_serial_port_checker

bind spz_serial_port spz_serial_port_checker i_spz_serial_port_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .serial_in_i, .serial_in_o, .serial_in_oen, .serial_out_pin, .rx_irq, .tx_irq
);

// >>> spz_remote.sv
// Far-end serial device model: async frames and mode 0 shift slave
module spz_remote (
    input  wire logic pclk,
    input  wire logic clk_line,
    input  wire logic data_line,
    output logic      drive = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;

    task automatic send(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            drive <= f[i];
            repeat (per) @(posedge pclk);
        end
        drive <= 1'b1;
    endtask

    task automatic capture(output logic [10:0] f, input int n, input int per);
        int t;
        f = 11'h7ff;
        t = 0;
        while (clk_line !== 1'b0 && t < 20000) begin
            @(posedge pclk);
            t++;
        end
        repeat (per / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            f[i] = clk_line;
            repeat (per) @(posedge pclk);
        end
    endtask

    task automatic m0_shift(input logic [7:0] d, output logic [7:0] got, output int per);
        logic prev;
        int   n;
        int   t;
        int   first;
        got = 8'h00;
        per = 0;
        n = 0;
        t = 0;
        first = 0;
        prev = clk_line;
        drive <= d[0];
        while (n < 8 && t < 20000) begin
            @(posedge pclk);
            t++;
            if (clk_line === 1'b1 && prev === 1'b0) begin
                got[n] = data_line;
                if (n == 1) begin
                    per = t - first;
                end
                first = t;
                n++;
                drive <= (n < 8) ? d[n] : 1'b1;
            end
            prev = clk_line;
        end
    endtask
endmodule // spz_remote

// >>> tb.sv
// Testbench for the serial port block: registers and serial traffic
module tb
    import spz_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [SPZ_AW-1:0] A_HI   = SPZ_AW'({SPZ_IDX_CTRL_HI, 2'b00});
    localparam logic [SPZ_AW-1:0] A_LO   = SPZ_AW'({SPZ_IDX_CTRL_LO, 2'b00});
    localparam logic [SPZ_AW-1:0] A_BAUD = SPZ_AW'({SPZ_IDX_BAUD, 2'b00});
    localparam logic [SPZ_AW-1:0] A_DATA = SPZ_AW'({SPZ_IDX_DATA, 2'b00});
    localparam logic [7:0]  TX_HI [3] = '{8'h40, 8'h88, 8'hc0};
    localparam logic [7:0]  TX_LO [3] = '{8'h72, 8'h72, 8'hf2};
    localparam logic [7:0]  TX_D  [3] = '{8'ha5, 8'h3c, 8'h07};
    localparam int          TX_N  [3] = '{10, 11, 11};
    localparam int          TX_P  [3] = '{32, 16, 32};
    localparam logic [7:0]  RX_HI [3] = '{8'h52, 8'h92, 8'hd2};
    localparam logic [10:0] RX_F  [3] = '{{2'b11, 8'h3c, 1'b0}, {2'b11, 8'hc3, 1'b0},
                                          {2'b10, 8'h81, 1'b0}};
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [SPZ_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb;
    logic              serial_in_o, serial_in_oen, serial_out_pin, rx_irq, tx_irq;
    logic              rem_drive, err;
    wire logic         serial_line;
    logic [10:0]       frame, exp_f;
    logic [7:0]        got;
    int                per, error_cnt, samples_checked;

    assign serial_line = serial_in_oen ? rem_drive : serial_in_o;

    spz_serial_port i_spz_serial_port (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .serial_in_i(serial_line), .serial_in_o, .serial_in_oen, .serial_out_pin,
        .rx_irq, .tx_irq
    );
    spz_remote i_spz_remote (
        .pclk(pclk), .clk_line(serial_out_pin), .data_line(serial_line), .drive(rem_drive)
    );

    always #10 pclk = ~pclk;

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [SPZ_AW-1:0] a, input logic [7:0] d);
        int t;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 100);
        rd  = prdata;
        err = pslverr;
        if (t == 100) begin
            check("pready", 32'h0000_0000, 32'h0000_0001);
            give_verdict();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [SPZ_AW-1:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string n, input logic [SPZ_AW-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(n, rd, {24'h00_0000, e});
    endtask

    task automatic wait_irq(input logic rx);
        int t;
        t = 0;
        while ((rx ? rx_irq : tx_irq) !== 1'b1 && t < 5000) begin
            @(posedge pclk);
            t++;
        end
        check("irq", {31'h0000_0000, rx ? rx_irq : tx_irq}, 32'h0000_0001);
        if (t == 5000) begin
            give_verdict();
        end
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        check("run length", 32'h0000_0000, 32'h0000_0001);
        give_verdict();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        error_cnt = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("ctrl_high", A_HI, 8'h00);
        rd_chk("ctrl_low", A_LO, 8'h00);
        rd_chk("baud_divisor", A_BAUD, 8'h00);
        apb(1'b0, 12'h008, 8'h00);
        check("unmapped", {31'h0000_0000, err}, 32'h0000_0001);
        wr(A_BAUD, 8'h01);
        rd_chk("baud_divisor", A_BAUD, 8'h01);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            wr(A_HI, TX_HI[k]);
            wr(A_LO, TX_LO[k]);
            rd_chk("ctrl_low", A_LO, TX_LO[k]);
            fork
                i_spz_remote.capture(frame, TX_N[k], TX_P[k]);
                wr(A_DATA, TX_D[k]);
            join
            exp_f = (TX_N[k] == 10) ? {2'b11, TX_D[k], 1'b0} :
                    {1'b1, TX_LO[k][7] ? ^TX_D[k] : TX_HI[k][3], TX_D[k], 1'b0};
            check("frame", {21'h00_0000, frame}, {21'h00_0000, exp_f});
            wait_irq(1'b0);
            wr(A_LO, TX_LO[k] | 8'h01);
            rd_chk("tx pending", A_LO, TX_LO[k] | 8'h01);
            wr(A_LO, TX_LO[k]);
            rd_chk("tx pending", A_LO, TX_LO[k]);
        end
        $display("test async transmit done");
        for (int k = 0; k < 3; k++) begin
            wr(A_HI, RX_HI[k]);
            i_spz_remote.send(RX_F[k], TX_N[k], TX_P[k]);
            wait_irq(1'b1);
            rd_chk("rx data", A_DATA, RX_F[k][8:1]);
            if (k > 0) begin
                rd_chk("ctrl_high", A_HI, RX_HI[k] | {5'h00, RX_F[k][9], 2'b01});
            end
            wr(A_HI, 8'h00);
        end
        $display("test async receive done");
        fork
            i_spz_remote.m0_shift(8'hff, got, per);
            wr(A_DATA, 8'h96);
        join
        check("m0 tx data", {24'h00_0000, got}, 32'h0000_0096);
        check("m0 period", 32'(per), 32'h0000_0020);
        wait_irq(1'b0);
        wr(A_LO, 8'h72);
        $display("test shift transmit done");
        fork
            i_spz_remote.m0_shift(8'h5a, got, per);
            wr(A_HI, 8'h12);
        join
        wait_irq(1'b1);
        rd_chk("m0 rx data", A_DATA, 8'h5a);
        rd_chk("ctrl_high", A_HI, 8'h13);
        wr(A_HI, 8'h01);
        repeat (2) @(posedge pclk);
        check("rx irq gated", {31'h0000_0000, rx_irq}, 32'h0000_0000);
        rd_chk("ctrl_high", A_HI, 8'h01);
        $display("test shift receive done");
        give_verdict();
    end
endmodule // tb
